// *** include/lfp_pkg.sv ***
/*
 Constants for the LED channel fault-protection block.
 Assumes a 100 MHz core clock.
*/
package lfp_pkg;
   localparam int NUM_CH = 6;
   localparam int CLK_MHZ = 100;
   // Timeouts
   localparam int HOT_TIMEOUT_US = 800;
   localparam int HOT_TIMEOUT_CYC = HOT_TIMEOUT_US * CLK_MHZ;
   localparam int OPEN_PWM_CYCLES = 6;
   localparam int SHORT_CHECK_MS = 1;
   localparam int SHORT_CHECK_CYC = SHORT_CHECK_MS * 1000 * CLK_MHZ;
   // Current scale codes, in quarters of the initial setting
   localparam logic [2:0] SCALE_FULL = 3'h4;
   localparam logic [2:0] SCALE_75 = 3'h3;
   localparam logic [2:0] SCALE_50 = 3'h2;
   localparam logic [2:0] SCALE_25 = 3'h1;
   localparam logic [2:0] SCALE_RESET = SCALE_FULL;
   typedef enum logic [1:0] {
      LFP_RUN,
      LFP_HOT,
      LFP_LOCKED
   } lfp_state_e;
endpackage

// *** verilog/lfp_chan.sv ***
/*
 One LED channel: good/open classification, timeout and latched disable.
 Assumes synchronised comparator levels and a one-cycle PWM period tick.
*/
`timescale 1ns/1ps
module lfp_chan #(
   parameter int HOT_CYC = lfp_pkg::HOT_TIMEOUT_CYC,
   parameter int PWM_CYC = lfp_pkg::OPEN_PWM_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic at_target_in,
   input wire logic high_volt_in,
   input wire logic pwm_tick_in,
   input wire logic hot_in,
   input wire logic ovp_in,
   input wire logic active_in,
   output logic disabled_out
);
   localparam int CW = $clog2(HOT_CYC + 1);

   if (HOT_CYC < 1 || PWM_CYC < 1 || PWM_CYC > 16) begin : g_chk
      $error("lfp_chan: bad parameter");
   end

   logic good_q;
   logic open_q;
   logic [CW-1:0] hot_cnt_q;
   logic [3:0] pwm_cnt_q;
   logic open_now;
   logic expire;

   // Open: fell from good, or not good during lower OTP or overvoltage
   assign open_now = active_in && !at_target_in && (good_q || hot_in || ovp_in);
   assign expire = open_q && ((hot_in && hot_cnt_q == CW'(HOT_CYC - 1)) ||
                              (pwm_tick_in && pwm_cnt_q == 4'(PWM_CYC - 1)));

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || disabled_out) begin
         good_q <= 1'b0;
      end else if (active_in && at_target_in) begin
         good_q <= 1'b1;
      end else if (open_now) begin
         good_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         open_q <= 1'b0;
      end else begin
         open_q <= open_now || (open_q && active_in && !at_target_in);
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !open_q || at_target_in) begin
         hot_cnt_q <= '0;
         pwm_cnt_q <= 4'h0;
      end else begin
         if (hot_in) begin
            hot_cnt_q <= hot_cnt_q + CW'(1);
         end
         if (pwm_tick_in) begin
            pwm_cnt_q <= pwm_cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         disabled_out <= 1'b0;
      end else if (active_in && (high_volt_in || expire)) begin
         disabled_out <= 1'b1;
      end
   end
endmodule // lfp_chan

// *** verilog/lfp_top.sv ***
/*
 Fault-protection control for a six-channel LED driver.
 Assumes comparator results arrive asynchronously; enable low acts as reset.
*/
// Summary of operation
// - Lower over-temperature makes any channel below target an open channel.
// - Above lower threshold an open channel is disabled after 800 us.
// - Upper over-temperature stops boost and all current sources.
// - After cooling to about 100 degC restart at 75 percent current.
// - Further upper events repeat, stepping current to 50 then 25 percent.
// - Over-temperature never powers down; only enable low or a short does.
// - A short below 7.5 V without upper event stays enabled.
// - An open channel is switched off after 6 PWM cycles.
// - Channel above 7.5 V from zener open goes off four clocks after the input rises, with no PWM count.
// - On overvoltage, channels below target go off after PWM timeout.
// - Overvoltage sense is watched for falls below 20 percent.
// - Output or switch node short shuts down until enable goes low.
// - A channel above about 7.5 V is disabled as a short.
// - Channel at target is good; later drop below target means open.
`timescale 1ns/1ps
module lfp_top #(
   parameter int NCH = lfp_pkg::NUM_CH,
   parameter int HOT_CYC = lfp_pkg::HOT_TIMEOUT_CYC,
   parameter int SHORT_CYC = lfp_pkg::SHORT_CHECK_CYC
) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic ENABLE_IN,
   input wire logic [NCH-1:0] CH_AT_TARGET_IN,
   input wire logic [NCH-1:0] CH_HIGH_VOLT_IN,
   input wire logic PWM_PERIOD_IN,
   input wire logic TEMP_LOW_IN,
   input wire logic TEMP_HIGH_IN,
   input wire logic TEMP_COOL_IN,
   input wire logic OVERVOLTAGE_SENSE_HIGH_IN,
   input wire logic OVERVOLTAGE_SENSE_LOW_IN,
   input wire logic SWITCH_NODE_OK_IN,
   output logic [NCH-1:0] CH_ENABLE_OUT,
   output logic [NCH-1:0] CH_FAULT_OUT,
   output logic BOOST_RUN_OUT,
   output logic [2:0] CURRENT_SCALE_OUT,
   output logic THERMAL_SHDN_OUT,
   output logic SHORT_SHDN_OUT,
   output logic ACTIVE_OUT
);
   localparam int NIN = 2 * NCH + 8;
   localparam int SW = $clog2(SHORT_CYC + 1);

   if (NCH < 1 || HOT_CYC < 1 || SHORT_CYC < 1) begin : g_chk
      $error("lfp_top: bad parameter");
   end

   logic [NIN-1:0] raw;
   logic [NIN-1:0] sync1_q;
   logic [NIN-1:0] sync2_q;
   logic [NCH-1:0] at_target;
   logic [NCH-1:0] high_volt;
   logic pwm_s, pwm_prev_q, pwm_tick;
   logic hot, upper, cool, overvoltage_sense, ovp_low, lx_ok, en;
   logic run;
   logic short_trip;
   logic ovp_seen_q;
   logic [SW-1:0] start_cnt_q;
   logic [NCH-1:0] ch_dis;
   lfp_pkg::lfp_state_e state_q;
   logic [2:0] scale_q;

   assign raw = {ENABLE_IN, SWITCH_NODE_OK_IN, OVERVOLTAGE_SENSE_LOW_IN,
                 OVERVOLTAGE_SENSE_HIGH_IN, TEMP_COOL_IN, TEMP_HIGH_IN, TEMP_LOW_IN,
                 PWM_PERIOD_IN, CH_HIGH_VOLT_IN, CH_AT_TARGET_IN};

   // Two-stage synchronisers
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end

   assign at_target = sync2_q[NCH-1:0];
   assign high_volt = sync2_q[2*NCH-1:NCH];
   assign pwm_s = sync2_q[2*NCH];
   assign hot = sync2_q[2*NCH+1];
   assign upper = sync2_q[2*NCH+2];
   assign cool = sync2_q[2*NCH+3];
   assign overvoltage_sense = sync2_q[2*NCH+4];
   assign ovp_low = sync2_q[2*NCH+5];
   assign lx_ok = sync2_q[2*NCH+6];
   assign en = sync2_q[2*NCH+7];

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         pwm_prev_q <= 1'b0;
      end else begin
         pwm_prev_q <= pwm_s;
      end
   end
   assign pwm_tick = pwm_s && !pwm_prev_q;

   // Channels only judged while running normally
   assign run = en && (state_q == lfp_pkg::LFP_RUN);

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      lfp_chan #(
         .HOT_CYC(HOT_CYC),
         .PWM_CYC(lfp_pkg::OPEN_PWM_CYCLES)
      ) u_chan (
         .clk_in(CLK_IN),
         .rst_n_in(RST_N_IN && en),
         .at_target_in(at_target[i]),
         .high_volt_in(high_volt[i]),
         .pwm_tick_in(pwm_tick),
         .hot_in(hot),
         .ovp_in(overvoltage_sense),
         .active_in(run),
         .disabled_out(ch_dis[i])
      );
   end

   // Thermal state: enable low and a short lock are the only power-downs
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || !en) begin
         state_q <= lfp_pkg::LFP_RUN;
         scale_q <= lfp_pkg::SCALE_RESET;
      end else begin
         unique case (state_q)
            lfp_pkg::LFP_RUN: begin
               if (upper) begin
                  state_q <= lfp_pkg::LFP_HOT;
               end
            end
            lfp_pkg::LFP_HOT: begin
               if (cool) begin
                  state_q <= lfp_pkg::LFP_RUN;
                  if (scale_q != lfp_pkg::SCALE_25) begin
                     scale_q <= scale_q - 3'h1;
                  end
               end
            end
            lfp_pkg::LFP_LOCKED: begin
               state_q <= lfp_pkg::LFP_LOCKED;
            end
         endcase
         if (short_trip) begin
            state_q <= lfp_pkg::LFP_LOCKED;
         end
      end
   end

   // Output short detection: switch node from the end of the start window on, sense collapse later
   assign short_trip = (start_cnt_q == SW'(SHORT_CYC) && !lx_ok) ||
                       (ovp_seen_q && ovp_low);

   // Start-up window counter
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || !en) begin
         start_cnt_q <= '0;
      end else if (start_cnt_q != SW'(SHORT_CYC)) begin
         start_cnt_q <= start_cnt_q + SW'(1);
      end
   end

   // Sense must rise above the low level before a collapse counts
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || !en) begin
         ovp_seen_q <= 1'b0;
      end else if (!ovp_low) begin
         ovp_seen_q <= 1'b1;
      end
   end

   // Channel outputs; shorted channel below 7.5 V stays on
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         CH_ENABLE_OUT <= '0;
         CH_FAULT_OUT <= '0;
      end else begin
         CH_ENABLE_OUT <= run ? ~ch_dis : '0;
         CH_FAULT_OUT <= ch_dis;
      end
   end

   // Boost switching permission
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         BOOST_RUN_OUT <= 1'b0;
      end else begin
         BOOST_RUN_OUT <= run && !upper;
      end
   end

   // Current scale
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         CURRENT_SCALE_OUT <= lfp_pkg::SCALE_RESET;
      end else begin
         CURRENT_SCALE_OUT <= scale_q;
      end
   end

   // Thermal status
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         THERMAL_SHDN_OUT <= 1'b0;
      end else begin
         THERMAL_SHDN_OUT <= en && state_q == lfp_pkg::LFP_HOT;
      end
   end

   // Short and activity status
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         SHORT_SHDN_OUT <= 1'b0;
         ACTIVE_OUT <= 1'b0;
      end else begin
         SHORT_SHDN_OUT <= en && state_q == lfp_pkg::LFP_LOCKED;
         ACTIVE_OUT <= en && state_q != lfp_pkg::LFP_LOCKED;
      end
   end
endmodule // lfp_top

// *** dv/lfp_top_assertions.sv ***
/* Port checker for lfp_top.
   Bound to every lfp_top instance. */
`timescale 1ns/1ps
module lfp_top_assertions #(parameter int NCH = 6) (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic ENABLE_IN,
   input wire logic [NCH-1:0] CH_HIGH_VOLT_IN,
   input wire logic TEMP_HIGH_IN,
   input wire logic [NCH-1:0] CH_ENABLE_OUT,
   input wire logic [NCH-1:0] CH_FAULT_OUT,
   input wire logic BOOST_RUN_OUT,
   input wire logic [2:0] CURRENT_SCALE_OUT,
   input wire logic THERMAL_SHDN_OUT,
   input wire logic SHORT_SHDN_OUT,
   input wire logic ACTIVE_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   a_hot_stops_boost: assert property (
      TEMP_HIGH_IN && ACTIVE_OUT |-> ##[1:6] !BOOST_RUN_OUT) else $error("Boost ran hot");
   a_shdn_all_off: assert property (
      THERMAL_SHDN_OUT && $past(THERMAL_SHDN_OUT) |-> CH_ENABLE_OUT == '0 && !BOOST_RUN_OUT)
      else $error("Output on in shutdown");
   a_scale_step: assert property (
      $changed(CURRENT_SCALE_OUT) && CURRENT_SCALE_OUT != 3'h4
      |-> CURRENT_SCALE_OUT == $past(CURRENT_SCALE_OUT) - 3'h1) else $error("Bad scale step");
   a_fault_latch: assert property (
      (($past(CH_FAULT_OUT) & ~CH_FAULT_OUT) != '0) |-> !$past(ENABLE_IN, 2)
      || !$past(ENABLE_IN, 3) || !$past(ENABLE_IN, 4) || !$past(ENABLE_IN, 5))
      else $error("Fault flag dropped");
   a_fault_off: assert property (
      (CH_FAULT_OUT & $past(CH_FAULT_OUT) & CH_ENABLE_OUT) == '0) else $error("Faulty on");
   a_short_lock: assert property (
      SHORT_SHDN_OUT && $past(SHORT_SHDN_OUT) |-> !ACTIVE_OUT && !BOOST_RUN_OUT
      && CH_ENABLE_OUT == '0) else $error("Running after short");
   a_inactive_off: assert property (
      !ACTIVE_OUT && !$past(ACTIVE_OUT) |-> CH_ENABLE_OUT == '0 && !BOOST_RUN_OUT)
      else $error("Output on while inactive");
   a_hv_disable: assert property (
      (CH_HIGH_VOLT_IN[0] && BOOST_RUN_OUT) [*6] |=> CH_FAULT_OUT[0])
      else $error("High channel kept on");
   c_thermal: cover property ($rose(THERMAL_SHDN_OUT));
   c_open: cover property ($rose(CH_FAULT_OUT[1]));
   c_short: cover property ($rose(SHORT_SHDN_OUT));
endmodule // lfp_top_assertions
bind lfp_top lfp_top_assertions #(.NCH(NCH)) u_chk (
   .CLK_IN(CLK_IN),
   .RST_N_IN(RST_N_IN),
   .ENABLE_IN(ENABLE_IN),
   .CH_HIGH_VOLT_IN(CH_HIGH_VOLT_IN),
   .TEMP_HIGH_IN(TEMP_HIGH_IN),
   .CH_ENABLE_OUT(CH_ENABLE_OUT),
   .CH_FAULT_OUT(CH_FAULT_OUT),
   .BOOST_RUN_OUT(BOOST_RUN_OUT),
   .CURRENT_SCALE_OUT(CURRENT_SCALE_OUT),
   .THERMAL_SHDN_OUT(THERMAL_SHDN_OUT),
   .SHORT_SHDN_OUT(SHORT_SHDN_OUT),
   .ACTIVE_OUT(ACTIVE_OUT)
);

// *** dv/lfp_led_model.sv ***
/* LED strings and PWM period source seen from the block.
   Open strings are commanded by the bench. */
`timescale 1ns/1ps
module lfp_led_model (
   input wire logic clk_in,
   input wire logic [5:0] ch_enable_in,
   input wire logic [5:0] open_in,
   input wire logic pwm_run_in,
   output logic [5:0] at_target_out = 6'h00,
   output logic pwm_out = 1'b0
);
   logic [3:0] cnt_q = 4'h0;
   // Current reaches target one cycle after the source turns on
   always @(posedge clk_in) begin
      at_target_out <= ch_enable_in & ~open_in;
      cnt_q <= (cnt_q == 4'h4) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h4) pwm_out <= pwm_run_in & ~pwm_out;
   end
endmodule // lfp_led_model

// *** dv/lfp_top_bench.sv ***
/* Self-checking bench for lfp_top.
   Drives comparator levels; the LED model answers currents. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module lfp_top_bench;
   logic CLK_IN = 1'b0, RST_N_IN = 1'b0, ENABLE_IN = 1'b0, TEMP_LOW_IN = 1'b0;
   logic TEMP_HIGH_IN = 1'b0, TEMP_COOL_IN = 1'b0, OVERVOLTAGE_SENSE_HIGH_IN = 1'b0;
   logic OVERVOLTAGE_SENSE_LOW_IN = 1'b0, SWITCH_NODE_OK_IN = 1'b1, pwm_run = 1'b0;
   logic [5:0] CH_AT_TARGET_IN, CH_HIGH_VOLT_IN = 6'h00, open_mask = 6'h00;
   logic [5:0] CH_ENABLE_OUT, CH_FAULT_OUT;
   logic [2:0] CURRENT_SCALE_OUT;
   logic PWM_PERIOD_IN, BOOST_RUN_OUT, THERMAL_SHDN_OUT, SHORT_SHDN_OUT, ACTIVE_OUT;
   int fails = 0, checked = 0;
   lfp_top #(.HOT_CYC(20), .SHORT_CYC(30)) i_dut (
      .CLK_IN(CLK_IN),
      .RST_N_IN(RST_N_IN),
      .ENABLE_IN(ENABLE_IN),
      .CH_AT_TARGET_IN(CH_AT_TARGET_IN),
      .CH_HIGH_VOLT_IN(CH_HIGH_VOLT_IN),
      .PWM_PERIOD_IN(PWM_PERIOD_IN),
      .TEMP_LOW_IN(TEMP_LOW_IN),
      .TEMP_HIGH_IN(TEMP_HIGH_IN),
      .TEMP_COOL_IN(TEMP_COOL_IN),
      .OVERVOLTAGE_SENSE_HIGH_IN(OVERVOLTAGE_SENSE_HIGH_IN),
      .OVERVOLTAGE_SENSE_LOW_IN(OVERVOLTAGE_SENSE_LOW_IN),
      .SWITCH_NODE_OK_IN(SWITCH_NODE_OK_IN),
      .CH_ENABLE_OUT(CH_ENABLE_OUT),
      .CH_FAULT_OUT(CH_FAULT_OUT),
      .BOOST_RUN_OUT(BOOST_RUN_OUT),
      .CURRENT_SCALE_OUT(CURRENT_SCALE_OUT),
      .THERMAL_SHDN_OUT(THERMAL_SHDN_OUT),
      .SHORT_SHDN_OUT(SHORT_SHDN_OUT),
      .ACTIVE_OUT(ACTIVE_OUT)
   );
   lfp_led_model i_leds (.clk_in(CLK_IN), .ch_enable_in(CH_ENABLE_OUT), .open_in(open_mask),
      .pwm_run_in(pwm_run), .at_target_out(CH_AT_TARGET_IN), .pwm_out(PWM_PERIOD_IN));
   initial forever #5 CLK_IN = ~CLK_IN;
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_IN);
      #1;
   endtask
   task automatic t_start;
      cyc(3);
      `CHK({CH_ENABLE_OUT, CH_FAULT_OUT, BOOST_RUN_OUT}, 13'h0000)
      `CHK(CURRENT_SCALE_OUT, lfp_pkg::SCALE_RESET)
      @(posedge CLK_IN) RST_N_IN <= 1'b1;
      ENABLE_IN <= 1'b1;
      cyc(40);
      `CHK({ACTIVE_OUT, BOOST_RUN_OUT, CH_ENABLE_OUT}, 8'hff)
   endtask
   task automatic t_hv;
      @(posedge CLK_IN) CH_HIGH_VOLT_IN <= 6'h01;
      cyc(12);
      `CHK({CH_FAULT_OUT, CH_ENABLE_OUT}, 12'h07e)
   endtask
   task automatic t_open_pwm;
      @(posedge CLK_IN) pwm_run <= 1'b1;
      open_mask <= 6'h02;
      cyc(30);
      `CHK(CH_ENABLE_OUT, 6'h3e)
      cyc(60);
      `CHK({CH_FAULT_OUT, CH_ENABLE_OUT}, 12'h0fc)
      @(posedge CLK_IN) pwm_run <= 1'b0;
   endtask
   task automatic t_hot;
      @(posedge CLK_IN) TEMP_LOW_IN <= 1'b1;
      open_mask <= 6'h06;
      cyc(10);
      `CHK(CH_ENABLE_OUT, 6'h3c)
      cyc(30);
      `CHK({CH_FAULT_OUT, CH_ENABLE_OUT}, 12'h1f8)
      @(posedge CLK_IN) TEMP_LOW_IN <= 1'b0;
   endtask
   task automatic t_thermal;
      logic [2:0] exp_scale [4] = '{3'h3, 3'h2, 3'h1, 3'h1};
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK_IN) TEMP_HIGH_IN <= 1'b1;
         cyc(8);
         `CHK({THERMAL_SHDN_OUT, ACTIVE_OUT, BOOST_RUN_OUT, CH_ENABLE_OUT}, 9'h180)
         @(posedge CLK_IN) TEMP_HIGH_IN <= 1'b0;
         TEMP_COOL_IN <= 1'b1;
         cyc(8);
         `CHK(CURRENT_SCALE_OUT, exp_scale[i])
         `CHK({THERMAL_SHDN_OUT, BOOST_RUN_OUT, CH_ENABLE_OUT}, 8'h78)
         @(posedge CLK_IN) TEMP_COOL_IN <= 1'b0;
      end
   endtask
   task automatic t_enable;
      @(posedge CLK_IN) ENABLE_IN <= 1'b0;
      CH_HIGH_VOLT_IN <= 6'h00;
      open_mask <= 6'h00;
      cyc(8);
      `CHK({ACTIVE_OUT, CH_FAULT_OUT, CH_ENABLE_OUT, CURRENT_SCALE_OUT}, 16'h0004)
      @(posedge CLK_IN) ENABLE_IN <= 1'b1;
      cyc(40);
      `CHK({CH_FAULT_OUT, CH_ENABLE_OUT}, 12'h03f)
   endtask
   task automatic t_ovp;
      @(posedge CLK_IN) ENABLE_IN <= 1'b0;
      cyc(8);
      @(posedge CLK_IN) ENABLE_IN <= 1'b1;
      open_mask <= 6'h08;
      cyc(40);
      `CHK(CH_ENABLE_OUT, 6'h3f)
      @(posedge CLK_IN) OVERVOLTAGE_SENSE_HIGH_IN <= 1'b1;
      pwm_run <= 1'b1;
      cyc(90);
      `CHK({CH_FAULT_OUT, CH_ENABLE_OUT}, 12'h237)
      @(posedge CLK_IN) OVERVOLTAGE_SENSE_HIGH_IN <= 1'b0;
      pwm_run <= 1'b0;
   endtask
   task automatic t_short;
      @(posedge CLK_IN) OVERVOLTAGE_SENSE_LOW_IN <= 1'b1;
      cyc(8);
      @(posedge CLK_IN) OVERVOLTAGE_SENSE_LOW_IN <= 1'b0;
      cyc(8);
      `CHK({SHORT_SHDN_OUT, ACTIVE_OUT, BOOST_RUN_OUT}, 3'h4)
      @(posedge CLK_IN) ENABLE_IN <= 1'b0;
      SWITCH_NODE_OK_IN <= 1'b0;
      cyc(6);
      @(posedge CLK_IN) ENABLE_IN <= 1'b1;
      cyc(45);
      `CHK({SHORT_SHDN_OUT, ACTIVE_OUT, CH_ENABLE_OUT}, 8'h80)
   endtask
   task automatic complete_run;
      if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      t_start;
      t_hv;
      t_open_pwm;
      t_hot;
      t_thermal;
      t_enable;
      t_ovp;
      t_short;
      complete_run;
   end
   initial begin
      #50us;
      fails++;
      complete_run;
   end
endmodule // lfp_top_bench
